// >>> hdl/lds_defs.svh
// Constants for the laser driver control supervisor
`ifndef LDS_DEFS_SVH
`define LDS_DEFS_SVH

// Clock and serial timing
`define LDS_CLK_HZ 25000000
`define LDS_BAUD 115200
`define LDS_BAUD_DIV (`LDS_CLK_HZ / `LDS_BAUD)
// Soft-start ramp: time in microseconds, split into steps
`define LDS_SS_TIME_US 900
`define LDS_SS_STEPS 255
`define LDS_SS_TICK ((`LDS_SS_TIME_US * (`LDS_CLK_HZ / 1000000)) / `LDS_SS_STEPS)

// Board temperature thresholds, degrees C
`define LDS_OTW_ON 8'd67
`define LDS_OTW_OFF 8'd65
`define LDS_OTS_TRIP 8'd80

// Serial characters
`define LDS_CH_P 8'h50
`define LDS_CH_J 8'h4a
`define LDS_CH_K 8'h4b
`define LDS_CH_E 8'h45
`define LDS_CH_SP 8'h20
`define LDS_CH_CR 8'h0d
`define LDS_BUF_LEN 4'hb
`define LDS_LEN_J 4'h5
`define LDS_LEN_P 4'ha
`define LDS_LEN_K 4'hb
`define LDS_LEN_E 4'h6
`define LDS_ERR_FMT 16'h0000
`define LDS_ERR_UNK 16'h0001

// Serial parameter numbers
`define LDS_PAR_STATE 16'h0700
`define LDS_PAR_TEMP 16'h0800
`define LDS_PAR_TLO 16'h0801
`define LDS_PAR_THI 16'h0802

// State mask bit positions
`define LDS_ST_START 3
`define LDS_ST_STOP 4
`define LDS_ST_INTCUR 5
`define LDS_ST_EXTCUR 6
`define LDS_ST_EXTEN 9
`define LDS_ST_INTEN 10
`define LDS_ST_ALLOW 12
`define LDS_ST_DENY 13
`define LDS_ST_TDENY 14

// Register byte offsets and reset values
`define LDS_REG_CTRL 8'h00
`define LDS_REG_STATUS 8'h04
`define LDS_REG_TLIM 8'h08
`define LDS_REG_TEMP 8'h0c
`define LDS_TLO_RST 16'h0000
`define LDS_THI_RST 16'h05dc

`endif

// >>> hdl/lds_pkg.sv
// Types for the laser driver control supervisor
package lds_pkg;
   typedef logic [7:0] lds_byte_t;
   typedef enum logic [2:0] {
      LDS_IDLE = 3'b000,
      LDS_RECV = 3'b001,
      LDS_EXEC = 3'b011,
      LDS_SEND = 3'b010,
      LDS_DRAIN = 3'b110
   } lds_cmd_state_t;
   typedef struct packed {
      logic therm_deny;
      logic allow_ilk;
      logic ext_en;
      logic ext_cur;
      logic int_run;
   } lds_ctrl_t;
endpackage : lds_pkg

// >>> hdl/lds_uart_if.sv
// Byte stream between the serial port and the command engine
`timescale 1ns/1ns
`default_nettype none
interface lds_uart_if;
   import lds_pkg::*;
   logic rx_valid;
   lds_byte_t rx_data;
   logic tx_valid;
   lds_byte_t tx_data;
   logic tx_ready;
   modport phy(output rx_valid, output rx_data, output tx_ready,
      input tx_valid, input tx_data);
   modport core(input rx_valid, input rx_data, input tx_ready,
      output tx_valid, output tx_data);
endinterface : lds_uart_if
`default_nettype wire

// >>> hdl/lds_uart.sv
// 8N1 serial receiver and transmitter
`timescale 1ns/1ns
`default_nettype none
`include "lds_defs.svh"
module lds_uart (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Serial pins
   input wire logic rxd,
   output logic txd,
   // Byte stream
   lds_uart_if.phy u
);
   import lds_pkg::*;
   localparam logic [7:0] DIV_M1 = 8'(`LDS_BAUD_DIV - 1);
   localparam logic [7:0] HALF = 8'(`LDS_BAUD_DIV / 2);
   logic [7:0] rx_cnt_r;
   logic [3:0] rx_bit_r;
   logic rx_busy_r;
   logic [7:0] rx_sh_r;
   logic [7:0] tx_div_r;
   logic [3:0] tx_bit_r;
   logic tx_busy_r;
   logic [9:0] tx_sh_r;
   wire tx_tick = (tx_div_r == 8'h00);

   assign u.tx_ready = ~tx_busy_r;

   // Receive: centre on start bit, then sample once per bit
   always_ff @(posedge clk) begin
      u.rx_valid <= 1'b0;
      if (rst) begin
         rx_busy_r <= 1'b0;
         rx_cnt_r <= 8'h00;
         rx_bit_r <= 4'h0;
         rx_sh_r <= 8'h00;
         u.rx_data <= 8'h00;
      end else if (!rx_busy_r) begin
         if (!rxd) begin
            rx_busy_r <= 1'b1;
            rx_cnt_r <= HALF;
            rx_bit_r <= 4'h0;
         end
      end else if (rx_cnt_r != 8'h00) begin
         rx_cnt_r <= rx_cnt_r - 8'h01;
      end else begin
         rx_cnt_r <= DIV_M1;
         rx_bit_r <= rx_bit_r + 4'h1;
         if (rx_bit_r == 4'h0) begin
            // Glitch, not a start bit
            if (rxd) rx_busy_r <= 1'b0;
         end else if (rx_bit_r <= 4'h8) begin
            rx_sh_r <= {rxd, rx_sh_r[7:1]};
         end else begin
            rx_busy_r <= 1'b0;
            // Framing error drops the byte
            if (rxd) begin
               u.rx_valid <= 1'b1;
               u.rx_data <= rx_sh_r;
            end
         end
      end
   end

   // Transmit on the free-running baud enable
   always_ff @(posedge clk) begin
      if (rst) begin
         tx_div_r <= DIV_M1;
         tx_busy_r <= 1'b0;
         tx_bit_r <= 4'h0;
         tx_sh_r <= 10'h3ff;
         txd <= 1'b1;
      end else begin
         tx_div_r <= tx_tick ? DIV_M1 : tx_div_r - 8'h01;
         if (!tx_busy_r && u.tx_valid) begin
            tx_busy_r <= 1'b1;
            tx_bit_r <= 4'h0;
            tx_sh_r <= {1'b1, u.tx_data, 1'b0};
         end else if (tx_busy_r && tx_tick) begin
            txd <= tx_sh_r[0];
            tx_sh_r <= {1'b1, tx_sh_r[9:1]};
            tx_bit_r <= tx_bit_r + 4'h1;
            if (tx_bit_r == 4'ha) tx_busy_r <= 1'b0;
         end
      end
   end
endmodule : lds_uart
`default_nettype wire

// >>> hdl/lds_supervisor.sv
// Laser driver control supervisor with serial and Wishbone control
`timescale 1ns/1ns
`default_nettype none
`include "lds_defs.svh"
module lds_supervisor (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Wishbone slave
   input wire logic wb_cyc,
   input wire logic wb_stb,
   input wire logic wb_we,
   input wire logic [7:0] wb_adr,
   input wire logic [3:0] wb_sel,
   input wire logic [31:0] wb_dat_w,
   output logic [31:0] wb_dat_r,
   output logic wb_ack,
   // Control pins and sensors
   input wire logic enable_in,
   input wire logic interlock_in,
   input wire logic over_current,
   input wire logic [7:0] board_temp,
   input wire logic [15:0] therm_temp,
   // Power stage and status
   output logic stage_on,
   output logic [7:0] ramp_level,
   output logic crowbar,
   output logic clamp_fault,
   output logic ot_warn,
   // Serial link
   input wire logic uart_rxd,
   output logic uart_txd
);
   import lds_pkg::*;
   localparam logic [7:0] SS_TICK_M1 = 8'(`LDS_SS_TICK - 1);

   function automatic lds_ctrl_t apply_cmd(input lds_ctrl_t c,
                                           input logic [15:0] m);
      lds_ctrl_t n;
      n = c;
      if (m[`LDS_ST_START]) n.int_run = 1'b1;
      if (m[`LDS_ST_STOP]) n.int_run = 1'b0;
      if (m[`LDS_ST_INTCUR]) n.ext_cur = 1'b0;
      if (m[`LDS_ST_EXTCUR]) n.ext_cur = 1'b1;
      if (m[`LDS_ST_EXTEN]) n.ext_en = 1'b1;
      if (m[`LDS_ST_INTEN]) n.ext_en = 1'b0;
      if (m[`LDS_ST_ALLOW]) n.allow_ilk = 1'b1;
      if (m[`LDS_ST_DENY]) n.allow_ilk = 1'b0;
      if (m[`LDS_ST_TDENY]) n.therm_deny = 1'b1;
      return n;
   endfunction : apply_cmd

   function automatic logic [15:0] state_mask(input lds_ctrl_t c);
      logic [15:0] m;
      m = 16'h0000;
      m[`LDS_ST_START] = c.int_run;
      m[`LDS_ST_STOP] = ~c.int_run;
      m[`LDS_ST_EXTCUR] = c.ext_cur;
      m[`LDS_ST_INTCUR] = ~c.ext_cur;
      m[`LDS_ST_EXTEN] = c.ext_en;
      m[`LDS_ST_INTEN] = ~c.ext_en;
      m[`LDS_ST_ALLOW] = c.allow_ilk;
      m[`LDS_ST_DENY] = ~c.allow_ilk;
      m[`LDS_ST_TDENY] = c.therm_deny;
      return m;
   endfunction : state_mask

   // Returns {valid, nibble}
   function automatic logic [4:0] hex_val(input lds_byte_t b);
      if (b >= 8'h30 && b <= 8'h39) return {1'b1, b[3:0]};
      if ((b >= 8'h41 && b <= 8'h46) || (b >= 8'h61 && b <= 8'h66))
         return {1'b1, 4'(b[3:0] + 4'h9)};
      return 5'h00;
   endfunction : hex_val

   function automatic logic [16:0] hex4(input lds_byte_t a,
      input lds_byte_t b, input lds_byte_t c, input lds_byte_t d);
      logic [4:0] na, nb, nc, nd;
      na = hex_val(a);
      nb = hex_val(b);
      nc = hex_val(c);
      nd = hex_val(d);
      return {na[4] & nb[4] & nc[4] & nd[4],
              na[3:0], nb[3:0], nc[3:0], nd[3:0]};
   endfunction : hex4

   function automatic lds_byte_t hex_chr(input logic [3:0] n);
      return (n < 4'ha) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
   endfunction : hex_chr

   function automatic logic [31:0] wb_merge(input logic [31:0] o,
      input logic [31:0] n, input logic [3:0] s);
      logic [31:0] r;
      r = o;
      for (int i = 0; i < 4; i++)
         if (s[i]) r[8*i +: 8] = n[8*i +: 8];
      return r;
   endfunction : wb_merge

   lds_uart_if u();
   lds_uart phy (
      .clk(clk),
      .rst(rst),
      .rxd(uart_rxd),
      .txd(uart_txd),
      .u(u)
   );

   lds_ctrl_t ctrl_r, ctrl_nxt;
   logic [15:0] tlo_r, thi_r, tlo_nxt, thi_nxt;
   logic en_s1_r, en_s2_r, ilk_s1_r, ilk_s2_r, run_d_r;
   logic fault_r;
   logic [7:0] ss_cnt_r;
   lds_cmd_state_t st_r;
   lds_byte_t rbuf_r [0:10];
   logic [3:0] rlen_r, tlen_r, tidx_r;
   lds_byte_t resp_lead_r;
   logic [15:0] resp_par_r, resp_val_r;
   logic drain_r, tx_valid_r;
   lds_byte_t tx_byte, tx_data_r;
   logic [31:0] rd_mux;
   logic wr_ctrl, wr_tlim;

   // serial engine runs 8N1 at the fixed divider
   assign u.tx_valid = tx_valid_r;
   assign u.tx_data = tx_data_r;

   // Supervisor decisions
   wire run_req = ctrl_r.ext_en ? en_s2_r : ctrl_r.int_run;
   wire run_edge = run_req & ~run_d_r;
   wire ilk_ok = ~ctrl_r.allow_ilk | ~ilk_s2_r;
   wire therm_in = (therm_temp >= tlo_r) && (therm_temp <= thi_r);
   wire therm_ok = ctrl_r.therm_deny | therm_in;
   wire trip = over_current | (board_temp > `LDS_OTS_TRIP);
   wire fault_nxt = fault_r | trip;
   wire stage_nxt = run_req & ilk_ok & therm_ok & ~fault_nxt;
   wire ss_tick = (ss_cnt_r == 8'h00);

   // Command decode on the received buffer
   wire [16:0] par_h = hex4(rbuf_r[1], rbuf_r[2], rbuf_r[3], rbuf_r[4]);
   wire [16:0] val_h = hex4(rbuf_r[6], rbuf_r[7], rbuf_r[8], rbuf_r[9]);
   wire is_j = (rbuf_r[0] == `LDS_CH_J);
   wire is_p = (rbuf_r[0] == `LDS_CH_P);
   wire j_ok = is_j && rlen_r == `LDS_LEN_J && par_h[16];
   wire p_ok = is_p && rlen_r == `LDS_LEN_P && par_h[16] && val_h[16]
      && rbuf_r[5] == `LDS_CH_SP;
   wire par_state = par_h[15:0] == `LDS_PAR_STATE;
   wire par_temp = par_h[15:0] == `LDS_PAR_TEMP;
   wire par_tlo = par_h[15:0] == `LDS_PAR_TLO;
   wire par_thi = par_h[15:0] == `LDS_PAR_THI;
   wire par_known = par_state | par_temp | par_tlo | par_thi;
   // thermistor temperature served on a get
   wire [15:0] par_rd = par_state ? state_mask(ctrl_r) :
      par_temp ? therm_temp : par_tlo ? tlo_r : thi_r;
   wire exec_p = (st_r == LDS_EXEC) && p_ok;
   wire rx_cr = u.rx_data == `LDS_CH_CR;
   wire rx_full = (st_r == LDS_RECV) && u.rx_valid && !rx_cr
      && rlen_r == `LDS_BUF_LEN;

   // both paths may change the state at any time
   wire wb_req = wb_cyc & wb_stb & ~wb_ack;
   wire [15:0] wb_mask = wr_ctrl ? wb_dat_w[15:0] : 16'h0000;
   wire [15:0] ser_mask = (exec_p && par_state) ? val_h[15:0] : 16'h0000;
   assign ctrl_nxt = apply_cmd(apply_cmd(ctrl_r, wb_mask), ser_mask);
   wire [31:0] tlim_m = wb_merge({thi_r, tlo_r}, wb_dat_w, wb_sel);
   assign tlo_nxt = (exec_p && par_tlo) ? val_h[15:0] :
      wr_tlim ? tlim_m[15:0] : tlo_r;
   assign thi_nxt = (exec_p && par_thi) ? val_h[15:0] :
      wr_tlim ? tlim_m[31:16] : thi_r;

   // Register decode
   always_comb begin
      wr_ctrl = 1'b0;
      wr_tlim = 1'b0;
      rd_mux = 32'h00000000;
      if (wb_adr == `LDS_REG_CTRL) begin
         wr_ctrl = wb_req & wb_we & (&wb_sel[1:0]);
         rd_mux = {16'h0000, state_mask(ctrl_r)};
      end else if (wb_adr == `LDS_REG_STATUS) begin
         rd_mux = {8'h00, board_temp, ramp_level, 1'b0, st_r != LDS_IDLE,
            en_s2_r, ~ilk_s2_r, therm_in, ot_warn, fault_r, stage_on};
      end else if (wb_adr == `LDS_REG_TLIM) begin
         wr_tlim = wb_req & wb_we;
         rd_mux = {thi_r, tlo_r};
      end else if (wb_adr == `LDS_REG_TEMP) begin
         rd_mux = {16'h0000, therm_temp};
      end
   end

   // Reply byte, K carries a value and E only a code
   always_comb begin
      tx_byte = `LDS_CH_CR;
      if (tidx_r == 4'h0) tx_byte = resp_lead_r;
      else if (tidx_r <= 4'h4)
         tx_byte = hex_chr(4'(resp_par_r >> (6'd16 - {tidx_r, 2'b00})));
      else if (resp_lead_r == `LDS_CH_K && tidx_r == 4'h5)
         tx_byte = `LDS_CH_SP;
      else if (resp_lead_r == `LDS_CH_K && tidx_r <= 4'h9)
         tx_byte = hex_chr(4'(resp_val_r >> (6'd36 - {tidx_r, 2'b00})));
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wb_ack <= 1'b0;
         wb_dat_r <= 32'h00000000;
      end else begin
         wb_ack <= wb_req;
         wb_dat_r <= wb_req ? rd_mux : 32'h00000000;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_r <= '{therm_deny: 1'b0, allow_ilk: 1'b1, ext_en: 1'b1,
            ext_cur: 1'b1, int_run: 1'b0};
         tlo_r <= `LDS_TLO_RST;
         thi_r <= `LDS_THI_RST;
      end else begin
         ctrl_r <= ctrl_nxt;
         tlo_r <= tlo_nxt;
         thi_r <= thi_nxt;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         {en_s1_r, en_s2_r} <= 2'b00;
         {ilk_s1_r, ilk_s2_r} <= 2'b11;
      end else begin
         {en_s1_r, en_s2_r} <= {enable_in, en_s1_r};
         {ilk_s1_r, ilk_s2_r} <= {interlock_in, ilk_s1_r};
      end
   end

   always_ff @(posedge clk) begin
      if (rst) fault_r <= 1'b0;
      else fault_r <= fault_nxt;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         stage_on <= 1'b0;
         run_d_r <= 1'b0;
      end else begin
         stage_on <= stage_nxt;
         run_d_r <= run_req;
      end
   end

   // clamp command and its status pin
   always_ff @(posedge clk) begin
      if (rst) begin
         crowbar <= 1'b0;
         clamp_fault <= 1'b0;
      end else begin
         crowbar <= fault_nxt;
         clamp_fault <= fault_nxt;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) ot_warn <= 1'b0;
      else if (board_temp > `LDS_OTW_ON) ot_warn <= 1'b1;
      else if (board_temp < `LDS_OTW_OFF) ot_warn <= 1'b0;
   end

   // ramp restarts from zero on every start edge
   always_ff @(posedge clk) begin
      if (rst || !stage_nxt || run_edge) begin
         ramp_level <= 8'h00;
         ss_cnt_r <= SS_TICK_M1;
      end else begin
         ss_cnt_r <= ss_tick ? SS_TICK_M1 : ss_cnt_r - 8'h01;
         if (ss_tick && ramp_level != 8'hff)
            ramp_level <= ramp_level + 8'h01;
      end
   end

   // Received bytes land in the command buffer
   always_ff @(posedge clk) begin
      if (u.rx_valid && (st_r == LDS_IDLE || st_r == LDS_RECV)
          && rlen_r != `LDS_BUF_LEN)
         rbuf_r[(st_r == LDS_IDLE) ? 4'h0 : rlen_r] <= u.rx_data;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_r <= LDS_IDLE;
         rlen_r <= 4'h0;
         tlen_r <= 4'h0;
         tidx_r <= 4'h0;
         resp_lead_r <= `LDS_CH_E;
         resp_par_r <= 16'h0000;
         resp_val_r <= 16'h0000;
         drain_r <= 1'b0;
         tx_valid_r <= 1'b0;
         tx_data_r <= `LDS_CH_CR;
      end else begin
         tx_valid_r <= 1'b0;
         case (st_r)
            LDS_IDLE: begin
               if (u.rx_valid && !rx_cr) begin
                  rlen_r <= 4'h1;
                  st_r <= LDS_RECV;
               end
            end
            LDS_RECV: begin
               if (u.rx_valid && rx_cr) begin
                  st_r <= LDS_EXEC;
               end else if (rx_full) begin
                  // overflow reply, then skip up to the CR
                  resp_lead_r <= `LDS_CH_E;
                  resp_par_r <= `LDS_ERR_FMT;
                  tlen_r <= `LDS_LEN_E;
                  tidx_r <= 4'h0;
                  drain_r <= 1'b1;
                  st_r <= LDS_SEND;
               end else if (u.rx_valid) begin
                  rlen_r <= rlen_r + 4'h1;
               end
            end
            LDS_EXEC: begin
               tidx_r <= 4'h0;
               drain_r <= 1'b0;
               if (p_ok) begin
                  st_r <= LDS_IDLE;
               // get answers K, unknown number gives zeros
               end else if (j_ok) begin
                  resp_lead_r <= `LDS_CH_K;
                  resp_par_r <= par_known ? par_h[15:0] : 16'h0000;
                  resp_val_r <= par_known ? par_rd : 16'h0000;
                  tlen_r <= `LDS_LEN_K;
                  st_r <= LDS_SEND;
               // error code, unknown prefix or bad format
               end else begin
                  resp_lead_r <= `LDS_CH_E;
                  resp_par_r <= (is_j || is_p) ? `LDS_ERR_FMT
                     : `LDS_ERR_UNK;
                  tlen_r <= `LDS_LEN_E;
                  st_r <= LDS_SEND;
               end
            end
            LDS_SEND: begin
               if (tidx_r == tlen_r) begin
                  st_r <= drain_r ? LDS_DRAIN : LDS_IDLE;
               end else if (u.tx_ready && !tx_valid_r) begin
                  // Byte latched before the index moves on
                  tx_data_r <= tx_byte;
                  tx_valid_r <= 1'b1;
                  tidx_r <= tidx_r + 4'h1;
               end
            end
            LDS_DRAIN: begin
               if (u.rx_valid && rx_cr) st_r <= LDS_IDLE;
            end
            default: st_r <= LDS_IDLE;
         endcase
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence seq_bad_cmd;
      st_r == LDS_EXEC && !j_ok && !p_ok;
   endsequence
   sequence seq_err_reply;
      st_r == LDS_SEND && resp_lead_r == `LDS_CH_E ##1 tx_valid_r;
   endsequence

   a_stage_needs_en: assert property (
      stage_on && $past(ctrl_r.ext_en) |-> $past(en_s2_r))
      else $error("stage on without enable");
   a_ramp_restart: assert property (
      run_edge && stage_nxt |=> ramp_level == 8'h00 && stage_on)
      else $error("ramp not restarted");
   a_crowbar_trip: assert property (
      trip |=> crowbar && !stage_on)
      else $error("trip did not fire crowbar");
   a_fault_ignores_en: assert property (
      fault_r && $rose(en_s2_r) |=> !stage_on [*2])
      else $error("enable acted during shutdown");
   a_fault_latched: assert property (
      fault_r |=> fault_r && crowbar)
      else $error("shutdown latch released");
   a_clamp_status: assert property (
      $rose(fault_r) |-> clamp_fault)
      else $error("clamp status missing");
   a_interlock_open: assert property (
      ctrl_r.allow_ilk && ilk_s2_r |=> !stage_on)
      else $error("output with interlock open");
   a_warn_hyst: assert property (
      ot_warn && board_temp >= `LDS_OTW_OFF |=> ot_warn)
      else $error("warning dropped too early");
   a_overtemp_trip: assert property (
      board_temp > `LDS_OTS_TRIP |=> fault_r)
      else $error("overtemperature not latched");
   a_therm_block: assert property (
      !therm_ok |=> !stage_on)
      else $error("output outside thermistor range");
   a_power_up: assert property (
      $past(rst) |-> ctrl_r.ext_cur && ctrl_r.ext_en && ctrl_r.allow_ilk)
      else $error("bad power-up state");
   a_reply_only: assert property (
      tx_valid_r |-> $past(st_r) == LDS_SEND)
      else $error("unsolicited transmit");
   a_error_reply: assert property (
      seq_bad_cmd |=> seq_err_reply)
      else $error("no error reply");
   a_overflow: assert property (
      rx_full |=> st_r == LDS_SEND && resp_par_r == `LDS_ERR_FMT)
      else $error("overflow not reported");
endmodule : lds_supervisor
`default_nettype wire

// >>> bench/lds_host.sv
// Serial host model for the command link
`timescale 1ns/1ns
`default_nettype none
module lds_host (
   // Clock
   input wire logic clk,
   // Serial lines
   input wire logic txd_in,
   output logic rxd_out
);
   initial rxd_out = 1'b1;
   task automatic put(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      @(posedge clk);
      for (int i = 0; i < 10; i++) begin
         rxd_out <= f[i];
         repeat (217) @(posedge clk);
      end
   endtask : put
   task automatic get(output logic [7:0] b);
      int n;
      n = 0;
      b = 8'h00;
      // Bounded so a silent device cannot hang the host
      while (txd_in !== 1'b0 && n < 3000) begin
         @(posedge clk);
         n++;
      end
      repeat (108) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
         repeat (217) @(posedge clk);
         b[i] = txd_in;
      end
      repeat (217) @(posedge clk);
   endtask : get
endmodule : lds_host
`default_nettype wire

// >>> bench/tb.sv
// Self-checking bench for the laser driver control supervisor
`timescale 1ns/1ns
`default_nettype none
module tb;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
   logic [7:0] wb_adr = 8'h00;
   logic [3:0] wb_sel = 4'hf;
   logic [31:0] wb_dat_w = 32'h0, wb_dat_r, q;
   logic wb_ack, enable_in = 1'b0, interlock_in = 1'b1, over_current = 1'b0;
   logic [7:0] board_temp = 8'h19, ramp_level;
   logic [15:0] therm_temp = 16'h0100;
   logic stage_on, crowbar, clamp_fault, ot_warn, rxd, txd;
   int fails = 0;
   int total_checks = 0;
   always #20 clk = ~clk;
   lds_supervisor dut_u (.clk(clk), .rst(rst), .wb_cyc(wb_cyc),
      .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
      .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
      .enable_in(enable_in), .interlock_in(interlock_in),
      .over_current(over_current), .board_temp(board_temp),
      .therm_temp(therm_temp), .stage_on(stage_on),
      .ramp_level(ramp_level), .crowbar(crowbar),
      .clamp_fault(clamp_fault), .ot_warn(ot_warn), .uart_rxd(rxd),
      .uart_txd(txd));
   lds_host host_u (.clk(clk), .txd_in(txd), .rxd_out(rxd));
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      total_checks++;
      if (s !== e) begin
         fails++;
         $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
   endtask : chk
   // Sample between edges so outputs have settled
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask : tick
   task automatic wb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r);
      @(posedge clk);
      {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat_w} <= {2'b11, w, a, d};
      // Ack and read data taken at the same rising edge
      do @(posedge clk); while (wb_ack !== 1'b1);
      r = wb_dat_r;
      {wb_cyc, wb_stb} <= 2'b00;
   endtask : wb
   task automatic t_reset();
      chk(32'({stage_on, crowbar, clamp_fault, ot_warn}), 0);
      wb(1'b0, 8'h00, 0, q);
      chk(q, 32'h1250);
      wb(1'b0, 8'h40, 0, q);
      chk(q, 0);
   endtask : t_reset
   task automatic t_run();
      @(posedge clk);
      {interlock_in, enable_in} <= 2'b01;
      tick(4);
      chk(32'(stage_on), 1);
      tick(100);
      chk(32'(ramp_level), 1);
      @(posedge clk);
      enable_in <= 1'b0;
      tick(4);
      chk(32'(stage_on), 0);
      @(posedge clk);
      enable_in <= 1'b1;
      tick(4);
      chk(32'({stage_on, ramp_level}), 32'h100);
      @(posedge clk);
      interlock_in <= 1'b1;
      tick(4);
      chk(32'(stage_on), 0);
      wb(1'b1, 8'h00, 32'h2000, q);
      tick(3);
      chk(32'(stage_on), 1);
      wb(1'b0, 8'h00, 0, q);
      chk(q, 32'h2250);
   endtask : t_run
   task automatic t_therm();
      @(posedge clk);
      therm_temp <= 16'h05dd;
      tick(3);
      chk(32'(stage_on), 0);
      @(posedge clk);
      therm_temp <= 16'h05dc;
      tick(3);
      chk(32'(stage_on), 1);
      wb(1'b0, 8'h0c, 0, q);
      chk(q, 32'h000005dc);
   endtask : t_therm
   task automatic t_warn();
      logic [7:0] t [5] = '{8'd67, 8'd68, 8'd66, 8'd65, 8'd64};
      logic [4:0] e = 5'b01110;
      foreach (t[i]) begin
         @(posedge clk);
         board_temp <= t[i];
         tick(3);
         chk(32'(ot_warn), 32'(e[4-i]));
      end
   endtask : t_warn
   task automatic t_link(input string c, input string r);
      logic [7:0] b;
      foreach (c[i]) host_u.put(c[i]);
      // Listen during the CR so an early reply is not missed
      fork
         host_u.put(8'h0d);
         foreach (r[i]) begin
            host_u.get(b);
            chk(32'(b), 32'(r[i]));
         end
      join
   endtask : t_link
   task automatic t_set();
      t_link("P0801 0100", "");
      wb(1'b0, 8'h08, 0, q);
      chk(q, 32'h05dc0100);
   endtask : t_set
   task automatic t_fault();
      @(posedge clk);
      board_temp <= 8'd81;
      tick(3);
      chk(32'({crowbar, clamp_fault, stage_on}), 6);
      @(posedge clk);
      {board_temp, enable_in} <= {8'd25, 1'b0};
      tick(3);
      @(posedge clk);
      enable_in <= 1'b1;
      tick(6);
      chk(32'({crowbar, clamp_fault, stage_on}), 6);
      @(posedge clk);
      rst <= 1'b1;
      tick(3);
      @(posedge clk);
      rst <= 1'b0;
      tick(1);
      chk(32'(crowbar), 0);
      @(posedge clk);
      over_current <= 1'b1;
      tick(2);
      chk(32'({crowbar, clamp_fault, stage_on}), 6);
   endtask : t_fault
   task automatic test_done();
      $display("checks %0d fails %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : test_done
   initial begin
      repeat (90000) @(posedge clk);
      fails++;
      test_done();
   end
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      tick(1);
      t_reset();
      t_run();
      t_therm();
      t_warn();
      t_link("J0800", "K0800 05DC\r");
      t_link("Q", "E0001\r");
      t_set();
      t_fault();
      test_done();
   end
endmodule : tb
`default_nettype wire
